/* dvs_cfg.svh */
`ifndef DVS_CFG_SVH
`define DVS_CFG_SVH

// controller clock
`define DVS_CLK_MHZ 200

// start delay after enable is registered, in microseconds
`define DVS_START_DELAY_US 8000

// one dac code step in microvolts
`define DVS_STEP_UV 6250

// slew rates in mV/us at the two strap settings
`define DVS_SLEW_MIN_MV_US 10
`define DVS_SLEW_MAX_MV_US 20

// cycles between dac steps, rounded up so the rate is never exceeded
`define DVS_SLEW_SLOW_CYC \
  ((`DVS_STEP_UV * `DVS_CLK_MHZ + `DVS_SLEW_MIN_MV_US * 1000 - 1) / (`DVS_SLEW_MIN_MV_US * 1000))
`define DVS_SLEW_FAST_CYC \
  ((`DVS_STEP_UV * `DVS_CLK_MHZ + `DVS_SLEW_MAX_MV_US * 1000 - 1) / (`DVS_SLEW_MAX_MV_US * 1000))

// boot dac codes selected by {clock, data} at enable
`define DVS_BOOT_CODE_0 8'h40
`define DVS_BOOT_CODE_1 8'h60
`define DVS_BOOT_CODE_2 8'h80
`define DVS_BOOT_CODE_3 8'ha0

// register byte offsets
`define DVS_REG_CTRL 4'h0
`define DVS_REG_STATUS 4'h4
`define DVS_REG_VOLT 4'h8
`define DVS_REG_STRAP 4'hc

// control register fields and reset value
`define DVS_CTRL_DE_BIT 0
`define DVS_CTRL_RESET 1'h0

// serial command frame length in bits
`define DVS_FRAME_BITS 4'h9

`endif

/* dvs_pkg.sv */
package dvs_pkg;

  // start-up sequence states
  typedef enum logic [2:0] {
    DVS_IDLE = 3'b000,
    DVS_DELAY = 3'b001,
    DVS_SOFT = 3'b010,
    DVS_RUN = 3'b011,
    DVS_SHUT = 3'b100
  } dvs_state_e;

  // dac code type
  typedef logic [7:0] dvs_code_t;

endpackage

/* dvs_phase.sv */
`timescale 1ns/10ps
// one pwm slave channel with its low-side gate
module dvs_phase (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic chan_en,
  input wire logic phase_clk,
  input wire logic window_hit,
  input wire logic zero_cross,
  input wire logic diode_emulation_mode,
  output logic pwm_q,
  output logic low_side_gate_q
);

  // pwm on at clock, off at window, low side fills the gap
  always_ff @(posedge sys_clk) begin
    if (rst || !chan_en) begin
      pwm_q <= 1'b0;
      low_side_gate_q <= 1'b0;
    end else if (phase_clk) begin
      // clock starts the pulse, low side released in the same cycle
      pwm_q <= 1'b1;
      low_side_gate_q <= 1'b0;
    end else if (pwm_q && window_hit) begin
      // ripple ramp reached window level
      pwm_q <= 1'b0;
      low_side_gate_q <= 1'b1;
    end else if (!pwm_q && diode_emulation_mode && zero_cross) begin
      // phase node at zero, stop reverse current until next clock
      low_side_gate_q <= 1'b0;
    end
  end

endmodule

/* dvs_sequencer.sv */
`timescale 1ns/10ps
`include "dvs_cfg.svh"
//
// Contract
// - core one to three phases, aux one or two
// - ramp trip gives one master pulse, ramp restarts
// - three phases get pulses in rotation
// - two phases alternate pulses
// - single phase takes every pulse
// - pwm rises on clock, falls at window
// - diode emulation drops low gate at zero
// - sense strap high disables that channel
// - first sense strap high disables regulator
// - start needs power-on-reset and enable high
// - boot code latched from serial pins at enable
// - fixed delay reading straps before soft-start
// - straps decoded during the start delay
// - soft-start steps dac at strapped slew
// - slew ten or twenty mV per microsecond
// - power good rises when soft-start ends
// - slew to new code, acknowledge increases
// - telemetry shifted out on host clock
// - thermal warning with hysteresis, thermal shutdown
module dvs_sequencer #(
  parameter int unsigned START_DELAY_CYC = `DVS_START_DELAY_US * `DVS_CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic enable,
  input wire logic por_ok,
  input wire logic serial_volt_clock,
  input wire logic serial_volt_data,
  input wire logic host_power_ok,
  input wire logic core_phase1_sense,
  input wire logic [1:0] core_phase_sense_strap,
  input wire logic aux_phase1_sense,
  input wire logic aux_phase_sense_strap,
  input wire logic aux_comp_strap,
  input wire logic aux_mode_slew_strap,
  input wire logic [1:0] ramp_trip,
  input wire logic [4:0] window_level_hit,
  input wire logic [4:0] phase_zero,
  input wire logic therm_warn_set,
  input wire logic therm_warn_clear,
  input wire logic therm_shutdown,
  output logic [4:0] pwm,
  output logic [4:0] low_side_gate,
  output logic [1:0] ramp_restart,
  output logic core_power_good,
  output logic aux_power_good,
  output logic [1:0] slew_change_ack,
  output logic serial_telem_data,
  output logic therm_warn,
  output logic therm_shut
);

  localparam int NRAW = 27;

  // pins gathered for the two-stage synchroniser
  wire [NRAW-1:0] raw_in = {enable, por_ok, serial_volt_clock, serial_volt_data,
    host_power_ok, core_phase1_sense, core_phase_sense_strap, aux_phase1_sense,
    aux_phase_sense_strap, aux_comp_strap, aux_mode_slew_strap, ramp_trip,
    window_level_hit, phase_zero, therm_warn_set, therm_warn_clear, therm_shutdown};
  logic [NRAW-1:0] meta_q; // first stage, read only by second
  logic [NRAW-1:0] sync_q; // second stage, safe to use

  // every outside level passes two flops
  always_ff @(posedge sys_clk) begin
    meta_q <= raw_in;
    sync_q <= meta_q;
  end

  // named views of synchronised inputs
  wire en_s = sync_q[26];
  wire por_s = sync_q[25];
  wire svc_s = sync_q[24];
  wire svd_s = sync_q[23];
  wire pok_s = sync_q[22];
  wire core_p1_s = sync_q[21];
  wire [1:0] core_ps_s = sync_q[20:19];
  wire aux_p1_s = sync_q[18];
  wire aux_ps_s = sync_q[17];
  wire comp_s = sync_q[16];
  wire slew_s = sync_q[15];
  wire [1:0] trip_s = sync_q[14:13];
  wire [4:0] win_s = sync_q[12:8];
  wire [4:0] zc_s = sync_q[7:3];
  wire warn_set_s = sync_q[2];
  wire warn_clr_s = sync_q[1];
  wire shut_s = sync_q[0];

  // sequence state and counters
  dvs_pkg::dvs_state_e state_q;
  dvs_pkg::dvs_state_e state_d;
  logic [31:0] dly_q; // start delay counter
  logic [1:0] boot_q; // latched boot selection
  logic [1:0] core_cnt_q; // active core phases, 0 when off
  logic [1:0] aux_cnt_q; // active aux phases, 0 when off
  logic slew_fast_q; // strap picked the fast slew
  logic comp_strap_q; // strap reading kept for the strap register
  logic ctrl_de_q; // diode emulation enable
  logic svc_prev_q; // serial clock history
  logic [8:0] cmd_sh_q; // incoming command shift
  logic [3:0] bit_q; // bits in current frame
  logic [15:0] telem_q; // outgoing telemetry shift
  logic [1:0] trip_prev_q; // ramp trip history
  logic [1:0] ptr_q [2]; // phase rotation pointer per regulator
  dvs_pkg::dvs_code_t tgt_q [2]; // target code per regulator
  dvs_pkg::dvs_code_t dac_q [2]; // present dac code per regulator
  logic [7:0] slew_cnt_q [2]; // step spacing counter
  logic [1:0] up_q; // increase in flight per regulator
  logic [1:0] pg_q; // power good per regulator
  logic warn_q; // thermal warning flag
  logic shut_q; // thermal shutdown flag
  logic wait_q; // bus wait request
  logic [31:0] rdata_q; // bus read data

  // start condition and phase gating
  wire go = en_s && por_s;
  wire running = (state_q == dvs_pkg::DVS_SOFT) || (state_q == dvs_pkg::DVS_RUN);
  wire delay_done = (dly_q == START_DELAY_CYC - 32'd1);
  wire [1:0] reg_en = {aux_cnt_q != 2'd0, core_cnt_q != 2'd0};

  // per regulator soft-start done, disabled ones count as done
  wire [1:0] done;
  assign done[0] = !reg_en[0] || (dac_q[0] == tgt_q[0]);
  assign done[1] = !reg_en[1] || (dac_q[1] == tgt_q[1]);

  // strap decode: phase1 high kills the regulator, later straps trim phases
  wire [1:0] core_cnt_d = core_p1_s ? 2'd0 :
    core_ps_s[0] ? 2'd1 : (core_ps_s[1] ? 2'd2 : 2'd3);
  wire [1:0] aux_cnt_d = aux_p1_s ? 2'd0 : (aux_ps_s ? 2'd1 : 2'd2);

  // boot code lookup from {clock, data}
  wire [7:0] boot_code = (boot_q == 2'd0) ? `DVS_BOOT_CODE_0 :
    (boot_q == 2'd1) ? `DVS_BOOT_CODE_1 :
    (boot_q == 2'd2) ? `DVS_BOOT_CODE_2 : `DVS_BOOT_CODE_3;

  // step spacing chosen by the slew strap
  wire [7:0] slew_cyc = slew_fast_q ? 8'(`DVS_SLEW_FAST_CYC) : 8'(`DVS_SLEW_SLOW_CYC);

  // state transitions
  always_comb begin
    state_d = state_q;
    case (state_q)
      dvs_pkg::DVS_IDLE: begin
        if (go) begin
          state_d = dvs_pkg::DVS_DELAY;
        end
      end
      dvs_pkg::DVS_DELAY: begin
        if (delay_done) begin
          state_d = dvs_pkg::DVS_SOFT;
        end
      end
      dvs_pkg::DVS_SOFT: begin
        if (done == 2'b11) begin
          state_d = dvs_pkg::DVS_RUN;
        end
      end
      dvs_pkg::DVS_RUN: state_d = dvs_pkg::DVS_RUN;
      dvs_pkg::DVS_SHUT: state_d = dvs_pkg::DVS_SHUT;
      default: state_d = dvs_pkg::DVS_IDLE;
    endcase
    // loss of enable or bias ends everything, thermal trip latches off
    if (state_q != dvs_pkg::DVS_IDLE && !go) begin
      state_d = dvs_pkg::DVS_IDLE;
    end else if (state_q != dvs_pkg::DVS_IDLE && shut_s) begin
      state_d = dvs_pkg::DVS_SHUT;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= dvs_pkg::DVS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // delay count and boot code latch at enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dly_q <= 32'd0;
      boot_q <= 2'd0;
    end else if (state_q == dvs_pkg::DVS_IDLE) begin
      dly_q <= 32'd0;
      if (go) begin
        boot_q <= {svc_s, svd_s};
      end
    end else if (state_q == dvs_pkg::DVS_DELAY) begin
      dly_q <= dly_q + 32'd1;
    end
  end

  // straps read continuously through the delay, frozen afterwards
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_cnt_q <= 2'd0;
      aux_cnt_q <= 2'd0;
      slew_fast_q <= 1'b0;
      comp_strap_q <= 1'b0;
    end else if (state_q == dvs_pkg::DVS_DELAY) begin
      core_cnt_q <= core_cnt_d;
      aux_cnt_q <= aux_cnt_d;
      slew_fast_q <= slew_s;
      comp_strap_q <= comp_s;
    end
  end

  // master clock: one pulse per ramp trip edge
  wire [1:0] mclk = trip_s & ~trip_prev_q & reg_en & {running, running};

  // phase clocks from the rotation pointers
  wire [4:0] pclk = {mclk[1] && ptr_q[1] == 2'd1, mclk[1] && ptr_q[1] == 2'd0,
    mclk[0] && ptr_q[0] == 2'd2, mclk[0] && ptr_q[0] == 2'd1,
    mclk[0] && ptr_q[0] == 2'd0};

  // channels allowed to switch
  wire [4:0] chan_en = {running && aux_cnt_q == 2'd2, running && reg_en[1],
    running && core_cnt_q == 2'd3, running && core_cnt_q >= 2'd2,
    running && reg_en[0]};

  // trip history, restart pulse and rotation
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trip_prev_q <= 2'b00;
      ramp_restart <= 2'b00;
      ptr_q[0] <= 2'd0;
      ptr_q[1] <= 2'd0;
    end else begin
      trip_prev_q <= trip_s;
      ramp_restart <= mclk;
      if (!running) begin
        ptr_q[0] <= 2'd0;
        ptr_q[1] <= 2'd0;
      end else begin
        // wrap after the last active phase
        if (mclk[0]) begin
          ptr_q[0] <= (ptr_q[0] >= core_cnt_q - 2'd1) ? 2'd0 : ptr_q[0] + 2'd1;
        end
        if (mclk[1]) begin
          ptr_q[1] <= (ptr_q[1] >= aux_cnt_q - 2'd1) ? 2'd0 : ptr_q[1] + 2'd1;
        end
      end
    end
  end

  // pwm slave channels
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_phase
      dvs_phase u_phase (
        .sys_clk(sys_clk),
        .rst(rst),
        .chan_en(chan_en[gi]),
        .phase_clk(pclk[gi]),
        .window_hit(win_s[gi]),
        .zero_cross(zc_s[gi]),
        .diode_emulation_mode(ctrl_de_q),
        .pwm_q(pwm[gi]),
        .low_side_gate_q(low_side_gate[gi])
      );
    end
  endgenerate

  // serial clock edges and command acceptance
  wire svc_rise = svc_s && !svc_prev_q;
  wire svc_fall = !svc_s && svc_prev_q;
  wire accept = pok_s && state_q == dvs_pkg::DVS_RUN;
  wire frame_end = accept && svc_rise && (bit_q == `DVS_FRAME_BITS - 4'd1);
  wire [8:0] cmd_word = {cmd_sh_q[7:0], svd_s};

  // command shift in, telemetry shift out
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      svc_prev_q <= 1'b0;
      cmd_sh_q <= 9'h000;
      bit_q <= 4'h0;
      telem_q <= 16'h0000;
    end else begin
      svc_prev_q <= svc_s;
      if (!accept) begin
        bit_q <= 4'h0;
        telem_q <= 16'h0000;
      end else if (svc_rise) begin
        cmd_sh_q <= cmd_word;
        bit_q <= frame_end ? 4'h0 : bit_q + 4'h1;
        if (frame_end) begin
          telem_q <= {dac_q[1], dac_q[0]};
        end
      end else if (svc_fall) begin
        telem_q <= {telem_q[14:0], 1'b0};
      end
    end
  end

  // telemetry pin follows the shift head
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_telem_data <= 1'b0;
    end else begin
      serial_telem_data <= telem_q[15];
    end
  end

  // per regulator target, dac ramp, acknowledge and power good
  generate
    for (gi = 0; gi < 2; gi++) begin : g_reg
      wire cmd_hit = frame_end && (cmd_word[8] == 1'(gi));
      wire step = running && reg_en[gi] && (dac_q[gi] != tgt_q[gi]) &&
        (slew_cnt_q[gi] >= slew_cyc - 8'd1);

      always_ff @(posedge sys_clk) begin
        if (rst || state_q == dvs_pkg::DVS_IDLE || state_q == dvs_pkg::DVS_SHUT) begin
          tgt_q[gi] <= 8'h00;
          dac_q[gi] <= 8'h00;
          slew_cnt_q[gi] <= 8'h00;
          up_q[gi] <= 1'b0;
          slew_change_ack[gi] <= 1'b0;
        end else begin
          if (state_q == dvs_pkg::DVS_DELAY) begin
            tgt_q[gi] <= boot_code;
          end else if (cmd_hit) begin
            tgt_q[gi] <= cmd_word[7:0];
            up_q[gi] <= cmd_word[7:0] > tgt_q[gi];
            slew_change_ack[gi] <= 1'b0;
          end else if (up_q[gi] && dac_q[gi] == tgt_q[gi]) begin
            up_q[gi] <= 1'b0;
            slew_change_ack[gi] <= 1'b1;
          end
          // one code step every slew interval
          if (step || dac_q[gi] == tgt_q[gi]) begin
            slew_cnt_q[gi] <= 8'h00;
          end else if (running) begin
            slew_cnt_q[gi] <= slew_cnt_q[gi] + 8'h01;
          end
          if (step) begin
            dac_q[gi] <= (dac_q[gi] < tgt_q[gi]) ? dac_q[gi] + 8'h01 :
              dac_q[gi] - 8'h01;
          end
        end
      end

      // power good once this regulator finishes soft-start
      always_ff @(posedge sys_clk) begin
        if (rst || !running) begin
          pg_q[gi] <= 1'b0;
        end else if (state_q == dvs_pkg::DVS_SOFT && reg_en[gi] && done[gi]) begin
          pg_q[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // power good pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_power_good <= 1'b0;
      aux_power_good <= 1'b0;
    end else begin
      core_power_good <= pg_q[0];
      aux_power_good <= pg_q[1];
    end
  end

  // thermal flags, set beats clear, shutdown sticks until idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      warn_q <= 1'b0;
      shut_q <= 1'b0;
    end else begin
      if (warn_set_s) begin
        warn_q <= 1'b1;
      end else if (warn_clr_s) begin
        warn_q <= 1'b0;
      end
      shut_q <= (state_d == dvs_pkg::DVS_SHUT);
    end
  end
  assign therm_warn = warn_q;
  assign therm_shut = shut_q;

  // bus decode
  wire bus_req = avs_read || avs_write;
  wire wr_ctrl = avs_write && !wait_q && avs_address == `DVS_REG_CTRL;
  wire [31:0] rd_mux = (avs_address == `DVS_REG_CTRL) ? {31'h0, ctrl_de_q} :
    (avs_address == `DVS_REG_STATUS) ? {20'h0, aux_cnt_q, core_cnt_q, pok_s, shut_q,
      warn_q, pg_q, state_q} :
    (avs_address == `DVS_REG_VOLT) ? {6'h0, boot_q, tgt_q[1], tgt_q[0], dac_q[0]} :
    (avs_address == `DVS_REG_STRAP) ? {28'h0, comp_strap_q, slew_fast_q, reg_en} :
    32'h0;

  // one wait cycle per access, data ready when wait drops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      ctrl_de_q <= `DVS_CTRL_RESET;
    end else begin
      wait_q <= !(bus_req && wait_q);
      if (avs_read && wait_q) begin
        rdata_q <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_de_q <= avs_writedata[`DVS_CTRL_DE_BIT];
      end
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

endmodule

/* dvs_seq_sva.sv */
`timescale 1ns/10ps
// watches bus answers, master pulses, start-up and thermal flags
module dvs_seq_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic enable,
  input wire logic por_ok,
  input wire logic core_phase1_sense,
  input wire logic [1:0] ramp_trip,
  input wire logic therm_warn_set,
  input wire logic therm_warn_clear,
  input wire logic [4:0] pwm,
  input wire logic [1:0] ramp_restart,
  input wire logic core_power_good,
  input wire logic aux_power_good,
  input wire logic therm_warn,
  input wire logic therm_shut
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] run_hist_q; // recent enable and supply history
  // shift in start permission each cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_hist_q <= 4'h0;
    end else begin
      run_hist_q <= {run_hist_q[2:0], enable && por_ok};
    end
  end
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_wait_cause; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_restart_pulse; ramp_restart[0] |=> !ramp_restart[0]; endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart too long");
  property p_restart_cause;
    ramp_restart[0] |-> $past(ramp_trip[0], 2) || $past(ramp_trip[0], 3) || $past(ramp_trip[0], 4);
  endproperty
  a_restart_cause: assert property (p_restart_cause) else $error("restart w/o trip");
  property p_pg_needs_en; $rose(core_power_good) |-> $past(enable, 3) && $past(por_ok, 3); endproperty
  a_pg_needs_en: assert property (p_pg_needs_en) else $error("power good w/o enable");
  property p_core_off; core_phase1_sense [*8] |-> !core_power_good && pwm[2:0] == 3'h0; endproperty
  a_core_off: assert property (p_core_off) else $error("core runs while strapped off");
  property p_warn_set; therm_warn_set [*4] |-> therm_warn; endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning not raised");
  property p_warn_clr; (therm_warn_clear && !therm_warn_set) [*4] |-> !therm_warn; endproperty
  a_warn_clr: assert property (p_warn_clr) else $error("warning not cleared");
  property p_shut_hold; therm_shut && (&run_hist_q) |=> therm_shut; endproperty
  a_shut_hold: assert property (p_shut_hold) else $error("shutdown released");
  property p_shut_pg; therm_shut [*4] |-> !core_power_good && !aux_power_good; endproperty
  a_shut_pg: assert property (p_shut_pg) else $error("power good in shutdown");
  c_pg: cover property ($rose(core_power_good));
  c_shut: cover property ($rose(therm_shut));
  c_aux_clk: cover property (ramp_restart[1]);
endmodule

bind dvs_sequencer dvs_seq_sva chk_i (.sys_clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
  .enable, .por_ok, .core_phase1_sense, .ramp_trip, .therm_warn_set, .therm_warn_clear, .pwm,
  .ramp_restart, .core_power_good, .aux_power_good, .therm_warn, .therm_shut);

/* dvs_host.sv */
`timescale 1ns/10ps
// host side of the voltage link: boot pins, frames and power ok
module dvs_host (
  input wire logic sys_clk,
  input wire logic core_power_good,
  input wire logic aux_power_good,
  output logic serial_volt_clock,
  output logic serial_volt_data,
  output logic host_power_ok
);
  logic po_en = 1'b0; // bench lets power ok through
  initial begin
    serial_volt_clock = 1'b0;
    serial_volt_data = 1'b0;
  end
  // power ok only once both power goods are seen
  always @(posedge sys_clk) begin
    host_power_ok <= po_en && core_power_good && aux_power_good;
  end
  // boot code parked on the pins before enable
  task boot(input logic [1:0] c);
    {serial_volt_clock, serial_volt_data} = c;
  endtask
  // nine bits msb first, link clock idles low
  task frame(input logic [8:0] w);
    serial_volt_clock = 1'b0;
    for (int i = 8; i >= 0; i--) begin
      serial_volt_data = w[i];
      #24 serial_volt_clock = 1'b1;
      #24 serial_volt_clock = 1'b0;
    end
    serial_volt_data = ~w[0]; // no stale bit after release
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam int DLY = 50; // shortened start delay
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, enable, por_ok, host_power_ok;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, seed;
  logic core_phase1_sense, aux_phase1_sense, aux_phase_sense_strap, aux_comp_strap;
  logic aux_mode_slew_strap, serial_volt_clock, serial_volt_data, serial_telem_data;
  logic [1:0] core_phase_sense_strap, ramp_trip, ramp_restart, slew_change_ack;
  logic [4:0] window_level_hit, phase_zero, pwm, low_side_gate;
  logic therm_warn_set, therm_warn_clear, therm_shutdown, therm_warn, therm_shut;
  logic core_power_good, aux_power_good;
  int error_cnt, n_compared, n;
  int boot_tab[4] = '{8'h40, 8'h60, 8'h80, 8'ha0}; // dac code per boot pin pair
  dvs_sequencer #(.START_DELAY_CYC(DLY)) uut (.sys_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .enable, .por_ok,
    .serial_volt_clock, .serial_volt_data, .host_power_ok, .core_phase1_sense,
    .core_phase_sense_strap, .aux_phase1_sense, .aux_phase_sense_strap, .aux_comp_strap,
    .aux_mode_slew_strap, .ramp_trip, .window_level_hit, .phase_zero, .therm_warn_set,
    .therm_warn_clear, .therm_shutdown, .pwm, .low_side_gate, .ramp_restart, .core_power_good,
    .aux_power_good, .slew_change_ack, .serial_telem_data, .therm_warn, .therm_shut);
  dvs_host host (.sys_clk, .core_power_good, .aux_power_good, .serial_volt_clock,
    .serial_volt_data, .host_power_ok);
  // free-running controller clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // xorshift source for timing and codes
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one bus access, held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    // a bus that never answers is a mismatch on its own
    if (n >= 50) error_cnt++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // one master pulse, then window end and low gate behaviour
  task automatic trip(input int r, input int ch, input logic de);
    ramp_trip[r] <= 1'b1;
    n = 0;
    @(posedge sys_clk);
    while (pwm === 5'h0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk(pwm, 32'h1 << ch);
    ramp_trip[r] <= 1'b0;
    repeat (rnd() % 4) @(posedge sys_clk);
    window_level_hit <= 5'h1f;
    repeat (6) @(posedge sys_clk);
    chk(pwm, 0);
    window_level_hit <= 5'h0;
    repeat (4) @(posedge sys_clk);
    chk(low_side_gate[ch], 1'b1);
    phase_zero <= 5'h1f;
    repeat (5) @(posedge sys_clk);
    chk(low_side_gate[ch], !de);
    phase_zero <= 5'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  // commands refused before power ok, then up and down slews
  task automatic frames;
    logic [7:0] t;
    t = 8'h41 + 8'(rnd() % 16);
    host.frame({1'b0, t});
    repeat (10) @(posedge sys_clk);
    bus(0, 4'h8, 0);
    chk(q[15:8], 8'h40);
    host.po_en = 1'b1;
    wait_hi(host_power_ok, 20);
    host.frame({1'b0, t});
    n = 0;
    while (slew_change_ack[0] !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    // word {0x40, 0x40} loaded at frame end, one falling edge shifted since
    chk(serial_telem_data, 1'b1);
    bus(0, 4'h8, 0);
    chk({slew_change_ack[0], q[15:0]}, {1'b1, t, t});
    host.frame({1'b1, 8'h3c});
    repeat (800) @(posedge sys_clk);
    bus(0, 4'h8, 0);
    chk({slew_change_ack[1], q[23:16]}, {1'b0, 8'h3c});
  endtask
  // start-up in one strap setting, then phase rotation
  task automatic up(input int k);
    logic [1:0] bc;
    int cyc, nc, na;
    bc = k[1:0];
    cyc = k[0] ? 63 : 125; // cycles per 6.25 mV step at 20 or 10 mV/us
    nc = (k == 1) ? 2 : (k == 2 ? 1 : 3);
    na = (k == 2) ? 1 : 2;
    enable <= 1'b0;
    host.po_en = 1'b0;
    repeat (8) @(posedge sys_clk);
    aux_mode_slew_strap <= k[0];
    aux_comp_strap <= k[1];
    aux_phase1_sense <= (k == 3);
    aux_phase_sense_strap <= (k == 2);
    core_phase_sense_strap <= (k == 1) ? 2'b10 : (k == 2 ? 2'b11 : 2'b00);
    host.boot(bc);
    repeat (4) @(posedge sys_clk);
    enable <= 1'b1;
    wait_hi(core_power_good, 30000);
    chk(n >= DLY + (boot_tab[bc] - 1) * cyc && n <= DLY + boot_tab[bc] * cyc + 12, 1);
    host.boot(2'b00);
    bus(0, 4'h8, 0);
    chk({q[25:24], q[7:0]}, {bc, boot_tab[bc][7:0]});
    bus(0, 4'hc, 0);
    chk(q[3:0], {k[1], k[0], k != 3, 1'b1});
    bus(0, 4'h4, 0);
    chk({aux_power_good, q[2:0]}, {k != 3, dvs_pkg::DVS_RUN});
    bus(1, 4'h0, {31'h0, k[1]});
    bus(0, 4'h0, 0);
    chk(q, {31'h0, k[1]});
    if (k == 0) frames();
    for (int j = 0; j < 2 * nc; j++) trip(0, j % nc, k[1]);
    if (k != 3) for (int j = 0; j < 2 * na; j++) trip(1, 3 + j % na, k[1]);
  endtask
  // watchdog against a hang
  initial begin
    repeat (95000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {rst, por_ok, seed} = {1'b1, 1'b1, 32'h964d};
    {avs_read, avs_write, avs_address, avs_writedata, enable, core_phase1_sense} = '0;
    {aux_phase1_sense, aux_phase_sense_strap, aux_comp_strap, aux_mode_slew_strap} = '0;
    {core_phase_sense_strap, ramp_trip, window_level_hit, phase_zero} = '0;
    {therm_warn_set, therm_warn_clear, therm_shutdown, error_cnt, n_compared} = '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(0, 4'h0, 0);
    chk(q, 0);
    bus(1, 4'h4, 32'hffffffff);
    bus(0, 4'h4, 0);
    chk(q[7:0], 0);
    bus(0, 4'h2, 0);
    chk(q, 0);
    for (int k = 0; k < 4; k++) up(k);
    therm_warn_set <= 1'b1;
    repeat (6) @(posedge sys_clk);
    therm_warn_set <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(therm_warn, 1);
    therm_warn_clear <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(therm_warn, 0);
    {therm_warn_clear, therm_shutdown} <= 2'b01;
    repeat (6) @(posedge sys_clk);
    therm_shutdown <= 1'b0;
    repeat (6) @(posedge sys_clk);
    bus(0, 4'h4, 0);
    chk({therm_shut, core_power_good, q[2:0]}, {2'b10, dvs_pkg::DVS_SHUT});
    // supply loss ends shutdown, and enable alone may not restart
    por_ok <= 1'b0;
    repeat (8) @(posedge sys_clk);
    bus(0, 4'h4, 0);
    chk(q[2:0], dvs_pkg::DVS_IDLE);
    {core_phase1_sense, aux_phase1_sense} <= 2'b10;
    repeat (8) @(posedge sys_clk);
    bus(0, 4'h4, 0);
    chk(q[2:0], dvs_pkg::DVS_IDLE);
    por_ok <= 1'b1;
    wait_hi(aux_power_good, 30000);
    chk({therm_shut, core_power_good, aux_power_good}, 3'b001);
    tally_and_finish();
  end
endmodule
